// ===== hw/cwg_regs.svh
// Purpose: Register offsets, field positions and reset values of the waveform generator.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes: Definitions only.
`ifndef CWG_REGS_SVH
`define CWG_REGS_SVH
`define CWG_CTRL_OFS  8'h00
`define CWG_POL_OFS   8'h04
`define CWG_CLK_OFS   8'h08
`define CWG_SEL_OFS   8'h0c
`define CWG_DBR_OFS   8'h10
`define CWG_DBF_OFS   8'h14
`define CWG_OVR_OFS   8'h18
`define CWG_STAT_OFS  8'h1c
`define CWG_EN_BIT    7
`define CWG_LOAD_BIT  6
`define CWG_SD_BIT    4
`define CWG_CS_BIT    0
`define CWG_SRC_COUNT 10
`define CWG_RST_BYTE  8'h00
`define CWG_RST_DB    6'h00
`define CWG_RST_NIB   4'h0
`endif

// ===== hw/cwg_pkg.sv
// Purpose: Types shared by the waveform generator.
// Assumes: Constants live in cwg_regs.svh.
// Notes: Direction codes are Gray along none, forward, reverse.
package cwg_pkg;
   typedef enum logic [2:0]
   {
      MODE_FWD  = 3'h2,
      MODE_REV  = 3'h3,
      MODE_HALF = 3'h4
   } mode_e;
   typedef enum logic [1:0]
   {
      DIR_NONE = 2'h0,
      DIR_FWD  = 2'h1,
      DIR_REV  = 2'h3
   } dir_e;
   typedef struct packed
   {
      logic [3:0] level;
      logic [3:0] enable;
   } drive_s;
endpackage

// ===== hw/complementary_deadband_waveform_gen.sv
// Purpose: Complementary waveform generator with dead band and full-bridge direction change.
// Assumes: Sources and the fast oscillator are asynchronous; APB runs on clk.
// Notes: Dead band advances on clk or on synchronised oscillator rising edges.
`timescale 1ns/100ps
`default_nettype none
`include "cwg_regs.svh"
// How it works
// RULE1 - Full-bridge direction change takes effect at next data rising edge.
// RULE2 - At direction change first and third outputs exchange static states.
// RULE3 - Forward to reverse: fourth output goes inactive, second starts modulating.
// RULE4 - New modulated output stays inactive until switch dead band counted out.
// RULE5 - Full-bridge dead band only at direction change, only on modulated output.
// RULE6 - Dead-band timing uses system clock or 16 MHz oscillator by one bit.
// RULE7 - Oscillator kept running in sleep when it clocks the dead band.
// RULE8 - Four-bit select picks data input from ten sources.
// RULE9 - Right after enable all four outputs start cleared.
// RULE10 - Each output has a polarity bit; set means active-low.
// RULE11 - Override levels bypass the polarity inversion.
// RULE12 - Two independent 6-bit dead-band counters, each from own count register.
// RULE13 - Counters count up from zero to loaded value on dead-band clock edges.
// RULE14 - Half-bridge: rising data edge delays first output by rising count.
// RULE15 - Full-bridge: rising count is reverse dead band on second output.
// RULE16 - Half-bridge: falling data edge delays second output by falling count.
// RULE17 - Full-bridge: falling count is forward dead band on fourth output.
// RULE18 - Interval spans 0 to 63 periods from the edge; zero means none.
// RULE19 - Input reversing before count ends keeps that output off this phase.
// RULE20 - Counts double-buffered: direct load when disabled, requested load when enabled.
// RULE21 - Asynchronous input allows up to one dead-band period of jitter.
// RULE22 - Mode 010 forward: first active, fourth modulated, second and third inactive.
// RULE23 - Mode 011 reverse: third active, second modulated, first and fourth inactive.
// RULE24 - Load request schedules load at rising edge after next fall; hardware clears it.
// RULE25 - Data input passes a two-stage synchroniser before edge detection.
// RULE26 - Disabling resets counters and direction state.
module complementary_deadband_waveform_gen
(
   input  wire logic                    clk,
   input  wire logic                    rstn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output var  logic [31:0]             prdata,
   output var  logic                    pready,
   output var  logic                    pslverr,
   input  wire logic [9:0]              sourceIn,
   input  wire logic                    internalFastOscillator,
   output var  cwg_pkg::drive_s         outDrive,
   output var  logic                    oscKeepAlive
);
   import cwg_pkg::*;

   logic [7:0]  controlRegZero;
   logic [3:0]  polarityControlReg;
   logic        clockConfigReg;
   logic [3:0]  inputSelectField;
   logic [5:0]  risingDeadbandCount;
   logic [5:0]  fallingDeadbandCount;
   logic [4:0]  overrideReg;
   logic [5:0]  dbVal [2];
   logic [9:0]  srcS1;
   logic [9:0]  srcS2;
   logic        oscS1;
   logic        oscS2;
   logic        oscS3;
   logic        dataS;
   logic        dataPrev;
   logic        loadArmed;
   dir_e        dir;
   logic [31:0] readMux;
   logic        hit;
   logic        access;
   logic        wrEn;
   logic        en;
   logic        loadReq;
   logic        half;
   logic        isFull;
   logic        wantRev;
   logic        riseEdge;
   logic        fallEdge;
   logic        change;
   logic        dbTick;
   logic [1:0]  start;
   logic [1:0]  abort;
   wire  [1:0]  okFlag;
   logic [3:0]  act;
   logic [3:0]  next_level;

   assign en      = controlRegZero[`CWG_EN_BIT];
   assign loadReq = controlRegZero[`CWG_LOAD_BIT];
   assign half    = controlRegZero[2:0] == MODE_HALF;
   assign isFull  = controlRegZero[2:0] == MODE_FWD || controlRegZero[2:0] == MODE_REV;
   assign wantRev = controlRegZero[2:0] == MODE_REV;

   // The bus answers with one wait state so that read data leaves a flip-flop.
   always_comb
   begin
      hit = 1'b1;
      readMux = 32'h0;
      case (paddr)
         `CWG_CTRL_OFS: readMux = {24'h0, controlRegZero};
         `CWG_POL_OFS:  readMux = {28'h0, polarityControlReg};
         `CWG_CLK_OFS:  readMux = {31'h0, clockConfigReg};
         `CWG_SEL_OFS:  readMux = {28'h0, inputSelectField};
         `CWG_DBR_OFS:  readMux = {26'h0, risingDeadbandCount};
         `CWG_DBF_OFS:  readMux = {26'h0, fallingDeadbandCount};
         `CWG_OVR_OFS:  readMux = {27'h0, overrideReg};
         `CWG_STAT_OFS: readMux = {18'h0, dbVal[0][3:0], dir, okFlag, dataS, loadArmed, act};
         default:       hit = 1'b0;
      endcase
   end

   assign access = psel && penable && pready;
   assign wrEn   = access && pwrite && hit;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready)
         begin
            prdata  <= pwrite ? 32'h0 : readMux;
            pslverr <= !hit;
         end
      end
   end

   // A hardware clear of the load request loses to a software write in the same cycle.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         controlRegZero <= `CWG_RST_BYTE;
      else if (wrEn && paddr == `CWG_CTRL_OFS)
         controlRegZero <= {pwdata[7:6], 3'h0, pwdata[2:0]};
      else if (en && loadReq && loadArmed && riseEdge)
         controlRegZero[`CWG_LOAD_BIT] <= 1'b0; // [RULE24]
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         polarityControlReg   <= `CWG_RST_NIB;
         clockConfigReg       <= 1'b0;
         inputSelectField     <= `CWG_RST_NIB;
         risingDeadbandCount  <= `CWG_RST_DB;
         fallingDeadbandCount <= `CWG_RST_DB;
         overrideReg          <= 5'h0;
      end
      else if (wrEn)
      begin
         case (paddr)
            `CWG_POL_OFS: polarityControlReg   <= pwdata[3:0];
            `CWG_CLK_OFS: clockConfigReg       <= pwdata[`CWG_CS_BIT];
            `CWG_SEL_OFS: inputSelectField     <= pwdata[3:0];
            `CWG_DBR_OFS: risingDeadbandCount  <= pwdata[5:0];
            `CWG_DBF_OFS: fallingDeadbandCount <= pwdata[5:0];
            `CWG_OVR_OFS: overrideReg          <= pwdata[4:0];
            default:      overrideReg          <= overrideReg;
         endcase
      end
   end

   // Loads keep their place in the data cycle so a running interval never sees a torn count.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dbVal[0] <= `CWG_RST_DB;
         dbVal[1]  <= `CWG_RST_DB;
         loadArmed <= 1'b0;
      end
      else if (!en)
      begin
         dbVal[0]  <= risingDeadbandCount; // [RULE20]
         dbVal[1]  <= fallingDeadbandCount; // [RULE20]
         loadArmed <= 1'b0;
      end
      else if (loadReq && loadArmed && riseEdge)
      begin
         dbVal[0]  <= risingDeadbandCount; // [RULE20] [RULE24]
         dbVal[1]  <= fallingDeadbandCount;
         loadArmed <= 1'b0;
      end
      else if (loadReq && fallEdge)
         loadArmed <= 1'b1; // [RULE24]
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         srcS1 <= 10'h0;
         srcS2 <= 10'h0;
         oscS1 <= 1'b0;
         oscS2 <= 1'b0;
         oscS3 <= 1'b0;
      end
      else
      begin
         srcS1 <= sourceIn; // [RULE25]
         srcS2 <= srcS1;
         oscS1 <= internalFastOscillator;
         oscS2 <= oscS1;
         oscS3 <= oscS2;
      end
   end

   // Codes 0 to 9 pick the sources in port order; higher codes give a quiet low input.
   always_comb
   begin
      dataS = 1'b0;
      if (inputSelectField < 4'(`CWG_SRC_COUNT))
         dataS = srcS2[inputSelectField]; // [RULE8]
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         dataPrev <= 1'b0;
      else
         dataPrev <= dataS;
   end

   assign riseEdge = en && dataS && !dataPrev;
   assign fallEdge = en && !dataS && dataPrev;
   // Edges are seen on clk, so the observed interval can grow by one period. [RULE21]
   assign dbTick = clockConfigReg ? (oscS2 && !oscS3) : 1'b1; // [RULE6]
   assign change = isFull && riseEdge && (dir == DIR_NONE || (dir == DIR_REV) != wantRev);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         dir <= DIR_NONE;
      else if (!en)
         dir <= DIR_NONE; // [RULE26]
      else if (change)
         dir <= wantRev ? DIR_REV : DIR_FWD; // [RULE1]
   end

   always_comb
   begin
      start[0] = half ? riseEdge : change && wantRev; // [RULE14] [RULE15]
      abort[0] = fallEdge;
      start[1] = half ? fallEdge : change && !wantRev; // [RULE16] [RULE17]
      abort[1] = half ? riseEdge : fallEdge;
   end

   for (genvar g = 0; g < 2; g++)
   begin : g_db
      logic [5:0] cnt;
      logic       busy;
      logic       ok;
      always_ff @(posedge clk or negedge rstn)
      begin
         if (!rstn)
         begin
            cnt  <= 6'h0;
            busy <= 1'b0;
            ok   <= 1'b0;
         end
         else if (!en)
         begin
            cnt  <= 6'h0; // [RULE26]
            busy <= 1'b0;
            ok   <= 1'b0;
         end
         else if (start[g])
         begin
            cnt  <= 6'h0; // [RULE13]
            busy <= dbVal[g] != 6'h0; // [RULE18]
            ok   <= dbVal[g] == 6'h0; // [RULE18]
         end
         else if (abort[g] && (half || busy))
         begin
            busy <= 1'b0; // [RULE19]
            ok   <= !half;
         end
         else if (busy && dbTick)
         begin
            cnt <= cnt + 6'h1; // [RULE12] [RULE13]
            if (cnt + 6'h1 == dbVal[g])
            begin
               busy <= 1'b0;
               ok   <= 1'b1;
            end
         end
      end
      assign okFlag[g] = ok;
   end

   // Static legs follow dir at once; only the modulated leg waits on a counter.
   always_comb
   begin
      act = 4'h0;
      if (half)
         act = {okFlag[1], okFlag[0], okFlag[1], okFlag[0]};
      else if (isFull)
      begin
         case (dir)
            DIR_FWD: act = {dataS && okFlag[1], 1'b0, 1'b0, 1'b1}; // [RULE22] [RULE5]
            DIR_REV: act = {1'b0, 1'b1, dataS && okFlag[0], 1'b0}; // [RULE23] [RULE3] [RULE4]
            default: act = 4'h0;
         endcase
      end
   end

   for (genvar i = 0; i < 4; i++)
   begin : g_out
      // Override levels are driven as written, polarity is skipped for them.
      assign next_level[i] = overrideReg[`CWG_SD_BIT] ? overrideReg[i] // [RULE11]
                                                      : act[i] ^ polarityControlReg[i]; // [RULE10]
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         outDrive     <= '0;
         oscKeepAlive <= 1'b0;
      end
      else
      begin
         outDrive.level  <= en ? next_level : 4'h0; // [RULE9] [RULE2]
         outDrive.enable <= en ? 4'hf : 4'h0; // [RULE9]
         // Holding the oscillator costs sleep current but keeps dead band alive.
         oscKeepAlive    <= en && clockConfigReg; // [RULE7]
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sequence s_to_rev;
      dir == DIR_FWD ##1 dir == DIR_REV;
   endsequence

   sequence s_rev_start;
      change && wantRev && dbVal[0] > 6'h1;
   endsequence

   a_dir_at_rise: assert property ($changed(dir) && $past(en) && en |-> $past(riseEdge)) // [RULE1]
      else $error("Direction changed away from a data rising edge.");

   a_static_swap: assert property (s_to_rev ##0 !overrideReg[`CWG_SD_BIT] && isFull // [RULE2]
      |=> outDrive.level[0] == polarityControlReg[0] && outDrive.level[2] != polarityControlReg[2])
      else $error("Static outputs did not swap at direction change.");

   a_fourth_off: assert property (s_to_rev ##0 !overrideReg[`CWG_SD_BIT] // [RULE3]
      |=> outDrive.level[3] == polarityControlReg[3])
      else $error("Fourth output still active after change to reverse.");

   a_mod_holdoff: assert property (s_rev_start |=> !okFlag[0] ##1 !okFlag[0]) // [RULE4]
      else $error("Modulated output released before dead band elapsed.");

   a_zero_nodelay: assert property (start[1] && dbVal[1] == 6'h0 |=> okFlag[1]) // [RULE18]
      else $error("Zero count still produced a dead band.");

   a_phase_abort: assert property (half && fallEdge |=> !okFlag[0]) // [RULE19]
      else $error("First output left on after input reversed.");

   a_load_clears: assert property (en && loadReq && loadArmed && riseEdge && !wrEn // [RULE24]
      |=> !loadReq && dbVal[0] == $past(risingDeadbandCount))
      else $error("Scheduled load did not happen or request not cleared.");

   a_override_raw: assert property (en && overrideReg[`CWG_SD_BIT] // [RULE11]
      |=> outDrive.level == $past(overrideReg[3:0]))
      else $error("Override level was altered.");

   a_disable_clear: assert property (!en |=> outDrive == '0 && dir == DIR_NONE && !okFlag[0]) // [RULE26]
      else $error("Disable did not clear the block.");

   a_osc_keep: assert property (en && clockConfigReg |=> oscKeepAlive) // [RULE7]
      else $error("Oscillator not held while selected.");

endmodule
`default_nettype wire

// ===== verif/bridge_switch_model.sv
// Purpose: Far-side model of the four power switch drivers of a bridge.
// Assumes: Legs pair the first with the second and the third with the fourth output.
// Notes: Switch delays are not modelled, so only overlap seen at the pins is counted.
`timescale 1ns/100ps
`default_nettype none
module bridge_switch_model
(
   input  wire logic            clk,
   input  wire logic            rstn,
   input  wire cwg_pkg::drive_s drive,
   input  wire logic [3:0]      polarity,
   output var  int              overlapCount
);
   import cwg_pkg::*;
   logic [3:0] switchOn;
   // A switch conducts only while its pin is driven to its active level.
   assign switchOn = drive.enable & (drive.level ^ polarity);
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         overlapCount <= 0;
      else if ((switchOn[0] && switchOn[1]) || (switchOn[2] && switchOn[3]))
         overlapCount <= overlapCount + 1;
   end
endmodule
`default_nettype wire

// ===== verif/complementary_deadband_waveform_gen_tb_top.sv
// Purpose: Self-checking bench for the complementary dead-band waveform generator.
// Assumes: Source 0 carries the waveform; the slave answers with one wait state.
// Notes: Delays are compared as differences, so the input pipeline cancels out.
`timescale 1ns/100ps
`default_nettype none
`include "cwg_regs.svh"
module complementary_deadband_waveform_gen_tb_top;
   import cwg_pkg::*;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [9:0]  sourceIn = 10'h000;
   logic        internalFastOscillator = 1'b0;
   drive_s      outDrive;
   logic        oscKeepAlive;
   logic [3:0]  polSet = 4'h0;
   int          overlapCount;
   int          errors = 0;
   int          cmpCount = 0;
   int          rise0;
   int          fall0;
   int          n;
   always #12.5 clk = ~clk;
   always #31.25 internalFastOscillator = ~internalFastOscillator;
   complementary_deadband_waveform_gen i_dut
   (
      .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sourceIn(sourceIn), .internalFastOscillator(internalFastOscillator),
      .outDrive(outDrive), .oscKeepAlive(oscKeepAlive)
   );
   bridge_switch_model i_switches
   (
      .clk(clk), .rstn(rstn), .drive(outDrive), .polarity(polSet), .overlapCount(overlapCount)
   );
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int k;
      k = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50) errors++;
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chkIn(input string nm, input int lo, input int hi, input int got);
      cmpCount++;
      if (got < lo || got > hi)
      begin
         errors++;
         $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask
   // Reads a register and compares only the bits under the mask.
   task automatic chkRd(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(nm, exp, q & m);
   endtask
   task automatic waitHi(input int idx, output int k);
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (outDrive.level[idx] !== 1'b1 && k < 300);
      if (k >= 300) errors++;
   endtask
   // Moves the data source and times the given output up to its high level.
   task automatic edgeDelay(input logic v, input int idx, output int k);
      sourceIn[0] <= v;
      waitHi(idx, k);
      repeat (80) @(posedge clk);
   endtask
   task automatic cfgRun(input logic [7:0] c, input logic [5:0] r, input logic [5:0] f);
      wr(`CWG_CTRL_OFS, 32'h0);
      wr(`CWG_DBR_OFS, {26'h0, r});
      wr(`CWG_DBF_OFS, {26'h0, f});
      wr(`CWG_CTRL_OFS, {24'h0, c});
   endtask
   task automatic testRegs();
      logic [31:0] q;
      logic        e;
      chkRd("ctrl reset", `CWG_CTRL_OFS, 32'hffffffff, 32'h0);
      chkRd("status reset", `CWG_STAT_OFS, 32'hffffffff, 32'h0);
      wr(`CWG_DBR_OFS, 32'hff);
      chkRd("rising count width", `CWG_DBR_OFS, 32'hffffffff, 32'h3f);
      wr(`CWG_DBF_OFS, 32'h40);
      chkRd("falling count width", `CWG_DBF_OFS, 32'hffffffff, 32'h0);
      apb(1'b0, 8'h20, 32'h0, q, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      $display("registers test done");
   endtask
   task automatic testSources();
      for (int i = 0; i < 10; i++)
      begin
         wr(`CWG_SEL_OFS, 32'(i));
         sourceIn <= 10'h001 << i;
         repeat (6) @(posedge clk);
         chkRd("selected source high", `CWG_STAT_OFS, 32'h20, 32'h20);
         sourceIn <= ~(10'h001 << i);
         repeat (6) @(posedge clk);
         chkRd("selected source low", `CWG_STAT_OFS, 32'h20, 32'h0);
      end
      wr(`CWG_SEL_OFS, 32'h0);
      sourceIn <= 10'h000;
      $display("sources test done");
   endtask
   task automatic testHalf();
      int hits;
      cfgRun(8'h84, 6'h00, 6'h00);
      edgeDelay(1'b1, 0, rise0);
      chkIn("zero rising count latency", 5, 5, rise0);
      edgeDelay(1'b0, 1, fall0);
      chkIn("zero falling count latency", 5, 5, fall0);
      cfgRun(8'h84, 6'h3f, 6'h09);
      edgeDelay(1'b1, 0, n);
      chkIn("rising dead band", rise0 + 63, rise0 + 63, n);
      edgeDelay(1'b0, 1, n);
      chkIn("falling dead band", fall0 + 9, fall0 + 9, n);
      cfgRun(8'h84, 6'h14, 6'h00);
      sourceIn[0] <= 1'b1;
      hits = 0;
      for (int i = 0; i < 60; i++)
      begin
         @(posedge clk);
         if (i == 8) sourceIn[0] <= 1'b0;
         hits += int'(outDrive.level[0] === 1'b1);
      end
      chkIn("aborted pulse", 0, 0, hits);
      $display("half-bridge test done");
   endtask
   task automatic testPolarity();
      cfgRun(8'h84, 6'h00, 6'h00);
      // Outputs start cleared, so one data cycle is needed to set the second leg.
      sourceIn[0] <= 1'b1;
      repeat (10) @(posedge clk);
      sourceIn[0] <= 1'b0;
      repeat (20) @(posedge clk);
      chk("levels active high", 32'ha, outDrive.level);
      polSet <= 4'hf;
      wr(`CWG_POL_OFS, 32'hf);
      repeat (4) @(posedge clk);
      chk("levels active low", 32'h5, outDrive.level);
      chk("drive enables", 32'hf, outDrive.enable);
      wr(`CWG_OVR_OFS, 32'h16);
      repeat (4) @(posedge clk);
      chk("override levels", 32'h6, outDrive.level);
      wr(`CWG_OVR_OFS, 32'h0);
      wr(`CWG_POL_OFS, 32'h0);
      polSet <= 4'h0;
      $display("polarity test done");
   endtask
   task automatic testBridge();
      cfgRun(8'h82, 6'h06, 6'h03);
      chk("levels after enable", 32'h0, outDrive.level);
      edgeDelay(1'b1, 0, n);
      chk("forward high", 32'h9, outDrive.level);
      sourceIn[0] <= 1'b0;
      repeat (20) @(posedge clk);
      chk("forward low", 32'h1, outDrive.level);
      wr(`CWG_CTRL_OFS, 32'h83);
      repeat (20) @(posedge clk);
      chk("before next rise", 32'h1, outDrive.level);
      sourceIn[0] <= 1'b1;
      waitHi(2, n);
      chk("statics swapped", 32'h4, outDrive.level);
      waitHi(1, n);
      chkIn("reverse dead band", 6, 8, n);
      repeat (20) @(posedge clk);
      chk("reverse high", 32'h6, outDrive.level);
      wr(`CWG_CTRL_OFS, 32'h82);
      sourceIn[0] <= 1'b0;
      repeat (20) @(posedge clk);
      sourceIn[0] <= 1'b1;
      waitHi(0, n);
      waitHi(3, n);
      chkIn("forward dead band", 3, 5, n);
      chkRd("direction", `CWG_STAT_OFS, 32'h300, {22'h0, DIR_FWD, 8'h0});
      wr(`CWG_CTRL_OFS, 32'h0);
      repeat (2) @(posedge clk);
      chk("disabled drive", 32'h0, outDrive);
      chkRd("direction cleared", `CWG_STAT_OFS, 32'h300, 32'h0);
      sourceIn[0] <= 1'b0;
      $display("full-bridge test done");
   endtask
   task automatic testLoad();
      cfgRun(8'h84, 6'h02, 6'h00);
      wr(`CWG_DBR_OFS, 32'hc);
      edgeDelay(1'b1, 0, n);
      chkIn("count held while enabled", rise0 + 2, rise0 + 2, n);
      edgeDelay(1'b0, 1, n);
      wr(`CWG_CTRL_OFS, 32'hc4);
      chkRd("load request set", `CWG_CTRL_OFS, 32'h40, 32'h40);
      edgeDelay(1'b1, 0, n);
      chkIn("no load before fall", rise0 + 2, rise0 + 2, n);
      edgeDelay(1'b0, 1, n);
      edgeDelay(1'b1, 0, n);
      chkRd("load request cleared", `CWG_CTRL_OFS, 32'h40, 32'h0);
      edgeDelay(1'b0, 1, n);
      edgeDelay(1'b1, 0, n);
      chkIn("loaded count", rise0 + 12, rise0 + 12, n);
      sourceIn[0] <= 1'b0;
      $display("load test done");
   endtask
   task automatic testOsc();
      wr(`CWG_CLK_OFS, 32'h1);
      cfgRun(8'h84, 6'h04, 6'h00);
      repeat (20) @(posedge clk);
      chk("oscillator kept", 32'h1, {31'h0, oscKeepAlive});
      edgeDelay(1'b1, 0, n);
      chkIn("oscillator dead band", rise0 + 6, rise0 + 13, n);
      edgeDelay(1'b0, 1, n);
      wr(`CWG_CTRL_OFS, 32'h0);
      wr(`CWG_CLK_OFS, 32'h0);
      repeat (2) @(posedge clk);
      chk("oscillator released", 32'h0, {31'h0, oscKeepAlive});
      $display("oscillator test done");
   endtask
   task automatic conclude();
      chk("switch overlap", 32'h0, overlapCount);
      $display("comparisons %0d mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // The run needs about 2000 cycles, so the limit leaves ample margin.
   initial
   begin
      #500000;
      errors++;
      conclude();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      testRegs();
      testSources();
      testHalf();
      testPolarity();
      testBridge();
      testLoad();
      testOsc();
      conclude();
   end
endmodule
`default_nettype wire
